/* File: logic/acr_pkg.sv */
package acr_pkg;
	// Register offsets (word indices, taken from adr_i[4:2])
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_MUX = 3'h2;
	localparam logic [2:0] OFS_REF = 3'h4;
	localparam logic [2:0] OFS_INTEN = 3'h6;
	localparam logic [2:0] OFS_STATUS = 3'h7;
	// Register field positions
	localparam int CTRL_RUN_STDBY = 7;
	localparam int CTRL_PAD_EN = 6;
	localparam int CTRL_EDGE_LO = 4;
	localparam int CTRL_LOW_PWR = 3;
	localparam int CTRL_HYS_LO = 1;
	localparam int CTRL_ENABLE = 0;
	localparam int MUX_INVERT = 7;
	localparam int MUX_POS_LO = 3;
	localparam int MUX_NEG_LO = 0;
	localparam int STAT_STATE = 4;
	localparam int STAT_FLAG = 0;
	localparam int INTEN_BIT = 0;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MUX_RST = 8'h00;
	localparam logic [7:0] REF_RST = 8'hff;
	localparam logic [7:0] INTEN_RST = 8'h00;
	// Edge mode codes and negative-select divider code
	localparam logic [1:0] EDGE_ANY = 2'h0;
	localparam logic [1:0] EDGE_RSVD = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_RISE = 2'h3;
	localparam logic [1:0] NEG_DIVREF = 2'h3;

	typedef struct packed {
		logic enable;
		logic low_power_select;
		logic [1:0] hysteresis_select;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
		logic [7:0] divider_reference_level;
		logic standby_run;
	} acr_core_ctl_s;
endpackage

/* File: logic/acr_regs.sv */
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
// Function
// - Standby-run bit keeps comparator alive in standby
// - Pad enable drives comparator output to pin
// - Edge field selects both, falling, rising
// - Low-power bit drives core low-current control
// - Hysteresis field drives core hysteresis selection
// - Enable bit switches comparator on or off
// - Invert bit inverts output for consumers
// - Positive select routes one of four pins
// - Negative select: three pins or divider reference
// - Eight-bit reference level, reset 0xff
// - Interrupt enable bit gates interrupt request
// - State bit is synchronized output, three-cycle lag
// - Status flag cleared by writing one
// - Flag set on selected output edge
// - Request high while enabled and flag set
// - Level event output follows comparator output
module acr_regs
	import acr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [4:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// Sleep state from the power manager
	input wire logic standby_i,
	// Analog core
	input wire logic cmp_raw_i,
	output acr_core_ctl_s core_ctl_o,
	// Output pad
	output logic pad_out_o,
	output logic pad_oe_o,
	// Consumers
	output logic event_level_o,
	output logic irq_o
);
	logic [7:0] ctrl_q;
	logic [7:0] mux_q;
	logic [7:0] ref_q;
	logic [7:0] inten_q;
	logic flag_q;
	logic sync1_q;
	logic sync2_q;
	logic state_q;
	logic prev_q;
	logic ack_q;
	logic err_q;
	logic [31:0] rdat_q;
	logic req;
	logic hit;
	logic wr;
	logic [2:0] reg_ofs;
	logic [1:0] edge_mode;
	logic running;
	logic inv_out;
	logic edge_hit;
	logic [7:0] rd_byte;
	logic [7:0] wr_byte;

	// Byte lane: index of the lowest set bit of sel
	function automatic logic [1:0] lane_of(input logic [3:0] sel);
		logic [1:0] l;
		l = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (sel[i]) begin
				l = 2'(i);
			end
		end
		return l;
	endfunction

	function automatic logic known_ofs(input logic [2:0] ofs);
		return ofs == OFS_CTRL || ofs == OFS_MUX || ofs == OFS_REF || ofs == OFS_INTEN || ofs == OFS_STATUS;
	endfunction

	// Each 8-bit register sits in the low byte of its own word
	assign reg_ofs = adr_i[4:2];
	assign req = cyc_i && stb_i && !ack_q && !err_q;
	assign hit = req && known_ofs(reg_ofs) && adr_i[1:0] == 2'h0;
	assign wr = hit && we_i && sel_i[0];
	assign wr_byte = dat_i[7:0];
	assign edge_mode = ctrl_q[CTRL_EDGE_LO +: 2];

	// Running drops in standby when standby-run is clear
	assign running = ctrl_q[CTRL_ENABLE] && (!standby_i || ctrl_q[CTRL_RUN_STDBY]);
	assign inv_out = sync2_q ^ mux_q[MUX_INVERT];

	always_comb begin
		edge_hit = 1'b0;
		unique case (edge_mode)
			EDGE_ANY: edge_hit = inv_out != prev_q;
			EDGE_RSVD: edge_hit = 1'b0;
			EDGE_FALL: edge_hit = prev_q && !inv_out;
			EDGE_RISE: edge_hit = !prev_q && inv_out;
		endcase
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (reg_ofs)
			OFS_CTRL: rd_byte = ctrl_q;
			OFS_MUX: rd_byte = mux_q & 8'h9b;
			OFS_REF: rd_byte = ref_q;
			OFS_INTEN: rd_byte = inten_q & 8'h01;
			OFS_STATUS: rd_byte = {3'h0, state_q, 3'h0, flag_q};
			default: rd_byte = 8'h00;
		endcase
	end

	// Bus handshake: one wait state, then ack or err for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= hit;
			err_q <= req && !hit;
			rdat_q <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			mux_q <= MUX_RST;
			ref_q <= REF_RST;
			inten_q <= INTEN_RST;
		end else if (wr) begin
			unique case (reg_ofs)
				OFS_CTRL: ctrl_q <= wr_byte;
				OFS_MUX: mux_q <= wr_byte & 8'h9b;
				OFS_REF: ref_q <= wr_byte;
				OFS_INTEN: inten_q <= wr_byte & 8'h01;
				default: ;
			endcase
		end
	end

	// Two-flop synchronizer plus state register: three-cycle lag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			state_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= cmp_raw_i;
			sync2_q <= sync1_q;
			if (running) begin
				state_q <= sync2_q;
			end
			prev_q <= inv_out;
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (running && edge_hit) begin
			flag_q <= 1'b1;
		end else if (wr && reg_ofs == OFS_STATUS && wr_byte[STAT_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_ctl_o <= '0;
			pad_out_o <= 1'b0;
			pad_oe_o <= 1'b0;
			event_level_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			core_ctl_o.enable <= running;
			core_ctl_o.standby_run <= ctrl_q[CTRL_RUN_STDBY];
			core_ctl_o.low_power_select <= ctrl_q[CTRL_LOW_PWR];
			core_ctl_o.hysteresis_select <= ctrl_q[CTRL_HYS_LO +: 2];
			core_ctl_o.positive_input_select <= mux_q[MUX_POS_LO +: 2];
			core_ctl_o.negative_input_select <= mux_q[MUX_NEG_LO +: 2];
			core_ctl_o.divider_reference_level <= ref_q;
			pad_out_o <= inv_out;
			pad_oe_o <= ctrl_q[CTRL_PAD_EN] && running;
			// Registered copy; pins cannot stay asynchronous here
			event_level_o <= inv_out && running;
			irq_o <= inten_q[INTEN_BIT] && flag_q;
		end
	end

	assign dat_o = rdat_q;
	assign ack_o = ack_q;
	assign err_o = err_q;
endmodule

/* File: sim/acr_core_model.sv */
`timescale 1ns/1ns
module acr_core_model
	import acr_pkg::*;
(
	input wire logic clk_i,
	input wire acr_core_ctl_s ctl_i,
	input wire logic lvl_i,
	output logic raw_o
);
	// Core switched off gives a low output
	always_ff @(posedge clk_i) raw_o <= ctl_i.enable & lvl_i;
endmodule

/* File: sim/acr_regs_props.sv */
`timescale 1ns/1ns
module acr_regs_props
	import acr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_o,
	input wire logic err_o,
	input wire logic standby_i,
	input wire acr_core_ctl_s core_ctl_o,
	input wire logic pad_out_o,
	input wire logic pad_oe_o,
	input wire logic event_level_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s; cyc_i && stb_i && !ack_o && !err_o; endsequence
	sequence halt_s; standby_i && !core_ctl_o.standby_run; endsequence
	ans_time_a: assert property (req_s |=> ack_o || err_o) else $error("late answer");
	ans_pulse_a: assert property (ack_o || err_o |=> !ack_o && !err_o) else $error("long answer");
	ref_rst_a: assert property ($fell(rst_i) |-> ##2 core_ctl_o.divider_reference_level == 8'hff)
		else $error("ref reset");
	oe_run_a: assert property (pad_oe_o |-> core_ctl_o.enable || $past(core_ctl_o.enable))
		else $error("oe");
	halt_a: assert property (halt_s ##1 halt_s |-> !pad_oe_o && !event_level_o) else $error("halt");
	event_a: assert property (event_level_o |-> pad_out_o) else $error("event");
	irq_clr_a: assert property ($fell(irq_o) |-> $past(we_i && stb_i) || $past(we_i && stb_i, 2))
		else $error("irq");
	// Sleep entry or exit also moves the enable, without any write
	ctl_wr_a: assert property (!$stable(core_ctl_o) |-> $past(rst_i || we_i && stb_i) ||
		$past(rst_i || we_i && stb_i, 2) || $past(standby_i) != $past(standby_i, 2)) else $error("ctl");
endmodule
bind acr_regs acr_regs_props i_acr_regs_props(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .err_o, .standby_i,
	.core_ctl_o, .pad_out_o, .pad_oe_o, .event_level_o, .irq_o);

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb
	import acr_pkg::*;
;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, standby_i = 0, lvl = 0, e, f;
	logic [4:0] adr_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic ack_o, err_o, raw, pad_out_o, pad_oe_o, event_level_o, irq_o;
	logic [7:0] v, m, d;
	logic [4:0] ad[5] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h1c};
	logic [7:0] rv[5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
	acr_core_ctl_s ctl;
	int num_errors = 0, n_checks = 0;
	always #25 clk_i = ~clk_i;
	acr_regs i_acr_regs(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i(4'hf), .adr_i, .dat_i, .dat_o, .ack_o,
		.err_o, .standby_i, .cmp_raw_i(raw), .core_ctl_o(ctl), .pad_out_o, .pad_oe_o, .event_level_o, .irq_o);
	acr_core_model i_acr_core_model(.clk_i, .ctl_i(ctl), .lvl_i(lvl), .raw_o(raw));
	function automatic logic exp_flag(input logic [1:0] md, input logic up);
		return md == EDGE_ANY || md == EDGE_RISE && up || md == EDGE_FALL && !up;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] dd);
		int n;
		n = 0;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, dd};
		do begin
			@(posedge clk_i);
			n++;
		end while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
		// Bounded wait so a dead slave counts an error instead of hanging
		if (n >= 20) begin
			num_errors++;
			$display("BAD %0t bus timeout", $time);
		end
		rd = dat_o;
		e = err_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask
	initial begin
		void'($urandom(32'h19c14d36));
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 5; i++) begin
			bus(0, ad[i], 8'h00);
			chk(rd[7:0], rv[i]);
		end
		bus(0, 5'h04, 8'h00);
		chk({7'h0, e}, 8'h01);
		v = 8'($urandom) | 8'h01;
		m = 8'($urandom) & 8'h9b;
		d = 8'($urandom);
		bus(1, 5'h00, v);
		bus(1, 5'h08, m);
		bus(1, 5'h10, d);
		chk({ctl.low_power_select, ctl.hysteresis_select, ctl.positive_input_select, ctl.negative_input_select,
			ctl.enable}, {v[3], v[2:1], m[4:3], m[1:0], v[0]});
		chk(ctl.divider_reference_level, d);
		bus(0, 5'h08, 8'h00);
		chk(rd[7:0], m);
		$display("regs done");
		bus(1, 5'h18, 8'h01);
		for (int k = 0; k < 8; k++) begin
			bus(1, 5'h00, {2'h1, k[1:0], 4'h1});
			// Invert flips the output, so clear the flag after it
			bus(1, 5'h08, {k[2], 7'h0});
			bus(1, 5'h1c, 8'h01);
			lvl <= ~lvl;
			repeat (8) @(posedge clk_i);
			f = exp_flag(k[1:0], lvl ^ k[2]);
			chk({4'h0, pad_out_o, pad_oe_o, event_level_o, irq_o}, {4'h0, lvl ^ k[2], 1'b1, lvl ^ k[2], f});
			bus(0, 5'h1c, 8'h00);
			// State bit shows the raw level, ahead of the invert
			chk(rd[7:0], {3'h0, lvl, 3'h0, f});
		end
		bus(1, 5'h1c, 8'h00);
		chk({7'h0, irq_o}, 8'h01);
		bus(1, 5'h18, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
		bus(1, 5'h18, 8'h01);
		bus(1, 5'h1c, 8'h01);
		chk({7'h0, irq_o}, 8'h00);
		$display("edges done");
		// Halted core keeps the state bit at the old level
		f = lvl;
		standby_i <= 1;
		lvl <= ~lvl;
		repeat (8) @(posedge clk_i);
		bus(0, 5'h1c, 8'h00);
		chk({6'h0, rd[4], pad_oe_o}, {6'h0, f, 1'b0});
		bus(1, 5'h00, 8'hc1);
		chk({7'h0, pad_oe_o}, 8'h01);
		$display("standby done");
		end_of_test();
	end
endmodule
